/* rtl/sfsp_status_protect.sv */
/*
 * sfsp_status_protect: status word, write latch, lock modes and busy signalling
 * of a serial flash, as seen behind the serial pins.
 * assumes: the array engine runs on sys_clk_i and reports busy, done and the
 * kind of operation; the host keeps chip select high between frames for at
 * least four system clocks.
 */
`default_nettype none

module sfsp_status_protect
    import sfsp_pkg::*;
#(
    parameter int unsigned TW_CYCLES = STATUS_WRITE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic wp_n_i,
    input wire logic array_busy_i,
    input wire logic array_done_i,
    input wire logic array_is_erase_i,
    output logic [4:0] prot_level_o,
    output logic prot_invert_o,
    output logic chip_erase_ok_o,
    output logic write_latch_o,
    output logic quad_io_enable_o,
    output logic [2:0] otp_lock_o,
    output logic [15:0] nv_image_o
);

    // ==========================================================
    // reset release
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ==========================================================
    // system-side state
    logic [15:0] cfg_q, nv_q;
    logic wel_q, vol_arm_q, rst_arm_q, esus_q, psus_q, wip_q;
    logic chip_erase_ok_q, asi_oe_q, asi_so_q, cs_prev_q;
    logic [31:0] tw_cnt_q;
    sfsp_state_e state_q;
    // ==========================================================
    // link-side state
    logic link_rst_n, first_q, asi_q, rd_arm_q, rd_hi_q, rd_so_q, rd_oe_q;
    logic [4:0] cnt_q;
    logic [7:0] op_q, op_next, rd_byte;
    logic [15:0] data_q;
    logic [2:0] idx_q;
    logic [3:0] dyn_l;
    // ==========================================================
    // crossings into the system clock
    logic cs_n_s, wp_n_s, asi_s;
    // idle levels at reset, so no false frame end or busy drive
    sfsp_sync3 #(
        .W(3),
        .RST_VAL(3'h6)
    ) u_sync_sys (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_q),
        .d_i({cs_n_i, wp_n_i, asi_q}),
        .q_o({cs_n_s, wp_n_s, asi_s})
    );
    // status bits that move during a frame, brought to the link clock
    assign link_rst_n = ~cs_n_i;
    sfsp_sync3 #(
        .W(4),
        .RST_VAL(4'h0)
    ) u_sync_link (
        .clk_i(sclk_i),
        .rst_n_i(link_rst_n),
        .d_i({esus_q, psus_q, wel_q, wip_q}),
        .q_o(dyn_l)
    );

    // ==========================================================
    // link: bit shifter on the rising serial clock
    assign op_next = {op_q[6:0], si_i};

    // new frame flag is set by deselect, so no edge after the frame is needed
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // counter and shifters survive deselect; the system side reads them then
    always_ff @(posedge sclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cnt_q <= 5'h00;
            op_q <= 8'h00;
            data_q <= 16'h0000;
        end else begin
            if (first_q) begin
                cnt_q <= 5'h01;
            end else if (cnt_q != CNT_SAT) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (first_q || cnt_q < CNT_OPCODE) begin
                op_q <= first_q ? {7'h00, si_i} : op_next;
            end else begin
                data_q <= {data_q[14:0], si_i};
            end
        end
    end

    // opcode decode at the eighth rising edge
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            asi_q <= 1'b0;
            rd_arm_q <= 1'b0;
            rd_hi_q <= 1'b0;
        end else if (!first_q && cnt_q == CNT_OPCODE_LAST) begin
            asi_q <= (op_next == OP_BUSY_SIG);
            rd_arm_q <= (op_next == OP_RD_LO) || (op_next == OP_RD_HI);
            rd_hi_q <= (op_next == OP_RD_HI);
        end
    end

    // ==========================================================
    // link: status byte out on the falling serial clock
    assign rd_byte = rd_hi_q ? {dyn_l[3], cfg_q[14:11], dyn_l[2], cfg_q[9:8]}
                             : {cfg_q[7:2], dyn_l[1], dyn_l[0]};
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            idx_q <= 3'h7;
            rd_so_q <= 1'b0;
            rd_oe_q <= 1'b0;
        end else if (rd_arm_q) begin
            rd_so_q <= rd_byte[idx_q];
            rd_oe_q <= 1'b1;
            idx_q <= idx_q - 3'h1;
        end
    end

    // ==========================================================
    // frame end decode and status write check
    logic frame_end, hw_locked, wr_len_ok, wr_two, wr_ok;
    logic [1:0] lock_mode;
    logic [15:0] cfg_new;
    logic [7:0] byte_lo, byte_hi;
    assign frame_end = cs_n_s && !cs_prev_q;
    assign lock_mode = {cfg_q[BIT_LOCK_HI], cfg_q[BIT_LOCK_LO]};
    always_comb begin
        // pin is data when quad on
        hw_locked = lock_mode[1] || (lock_mode == LOCK_HW && !wp_n_s && !cfg_q[BIT_QE]);
        wr_len_ok = (cnt_q == CNT_WR8) || (cnt_q == CNT_WR16);
        wr_two = (cnt_q == CNT_WR16);
        wr_ok = frame_end && op_q == OP_SR_WRITE && wr_len_ok && !hw_locked
              && (wel_q || vol_arm_q) && state_q == ST_IDLE && !array_busy_i;
        byte_lo = wr_two ? data_q[15:8] : data_q[7:0];
        byte_hi = data_q[7:0];
        cfg_new = cfg_q;
        cfg_new[BP_MSB:BP_LSB] = byte_lo[6:2];
        cfg_new[BIT_LOCK_LO] = byte_lo[7];
        if (wr_two) begin
            cfg_new[BIT_LOCK_HI] = byte_hi[0];
            cfg_new[BIT_QE] = byte_hi[1];
            cfg_new[OTP_MSB:OTP_LSB] = cfg_q[OTP_MSB:OTP_LSB] | byte_hi[5:3];
            cfg_new[BIT_INV] = byte_hi[6];
        end else begin
            cfg_new[BIT_LOCK_HI] = 1'b0;
            cfg_new[BIT_QE] = 1'b0;
            cfg_new[BIT_INV] = 1'b0;
        end
    end

    // ==========================================================
    // configuration bits
    // power-up reset is the power cycle: lock modes 1,0 fall back to 0,0
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_q <= STATUS_RESET;
            nv_q <= STATUS_RESET;
        end else if (wr_ok) begin
            cfg_q <= cfg_new;
            if (!vol_arm_q) begin
                nv_q <= cfg_new;
            end
        end
    end

    // ==========================================================
    // self-timed status write cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            tw_cnt_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (wr_ok && !vol_arm_q) begin
                        state_q <= ST_WRITE;
                        tw_cnt_q <= 32'h0000_0001;
                    end
                end
                ST_WRITE: begin
                    if (tw_cnt_q >= TW_CYCLES) begin
                        state_q <= ST_IDLE;
                    end else begin
                        tw_cnt_q <= tw_cnt_q + 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // write latch and volatile arm
    logic tw_done;
    assign tw_done = (state_q == ST_WRITE) && (tw_cnt_q >= TW_CYCLES);
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wel_q <= 1'b0;
        end else if (frame_end && cnt_q == CNT_OPCODE && op_q == OP_WR_EN) begin
            wel_q <= 1'b1;
        end else if (tw_done || array_done_i) begin
            wel_q <= 1'b0;
        end else if (frame_end && cnt_q == CNT_OPCODE
                     && (op_q == OP_WR_DIS || (op_q == OP_RST && rst_arm_q))) begin
            wel_q <= 1'b0;
        end
    end

    // arm holds only until the next completed frame
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            vol_arm_q <= 1'b0;
            rst_arm_q <= 1'b0;
        end else if (frame_end) begin
            vol_arm_q <= (cnt_q == CNT_OPCODE) && (op_q == OP_VOL_WEN);
            rst_arm_q <= (cnt_q == CNT_OPCODE) && (op_q == OP_RST_EN);
        end
    end

    // ==========================================================
    // suspend flags
    logic op_susp, op_res;
    assign op_susp = frame_end && cnt_q == CNT_OPCODE && (op_q == OP_SUSP_A || op_q == OP_SUSP_B);
    assign op_res = frame_end && cnt_q == CNT_OPCODE && (op_q == OP_RES_A || op_q == OP_RES_B);

    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            esus_q <= 1'b0;
            psus_q <= 1'b0;
        end else if (op_susp && array_busy_i) begin
            esus_q <= esus_q | array_is_erase_i;
            psus_q <= psus_q | !array_is_erase_i;
        end else if (op_res) begin
            esus_q <= 1'b0;
            psus_q <= 1'b0;
        end
    end

    // ==========================================================
    // busy, busy-signal output and protect outputs
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wip_q <= 1'b0;
            cs_prev_q <= 1'b1;
            chip_erase_ok_q <= 1'b1;
        end else begin
            wip_q <= array_busy_i || (state_q == ST_WRITE);
            cs_prev_q <= cs_n_s;
            chip_erase_ok_q <= (cfg_q[BP_MSB:BP_LSB] == BP_NONE);
        end
    end

    // no serial clock is needed: the busy level is followed on the system clock
    always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            asi_oe_q <= 1'b0;
            asi_so_q <= 1'b0;
        end else begin
            asi_oe_q <= asi_s && !cs_n_s;
            asi_so_q <= wip_q;
        end
    end

    // two flop sources share one pin; only one enable is high at a time
    assign so_o = asi_oe_q ? asi_so_q : rd_so_q;
    assign so_oe_o = asi_oe_q | rd_oe_q;
    assign prot_level_o = cfg_q[BP_MSB:BP_LSB];
    assign prot_invert_o = cfg_q[BIT_INV];
    assign chip_erase_ok_o = chip_erase_ok_q;
    assign write_latch_o = wel_q;
    assign quad_io_enable_o = cfg_q[BIT_QE];
    assign otp_lock_o = cfg_q[OTP_MSB:OTP_LSB];
    assign nv_image_o = nv_q;

endmodule // sfsp_status_protect

`default_nettype wire

/* rtl/sfsp_pkg.sv */
/*
 * sfsp_pkg: shared constants of the serial flash status and protection block.
 * assumes: a 40 MHz system clock; the link clock is the serial clock of the host.
 */
`default_nettype none

package sfsp_pkg;

    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_RD_LO = 8'h05;
    localparam logic [7:0] OP_RD_HI = 8'h35;
    localparam logic [7:0] OP_BUSY_SIG = 8'h25;
    localparam logic [7:0] OP_SR_WRITE = 8'h01;
    localparam logic [7:0] OP_WR_EN = 8'h06;
    localparam logic [7:0] OP_WR_DIS = 8'h04;
    localparam logic [7:0] OP_VOL_WEN = 8'h50;
    localparam logic [7:0] OP_SUSP_A = 8'h75;
    localparam logic [7:0] OP_SUSP_B = 8'hB0;
    localparam logic [7:0] OP_RES_A = 8'h7A;
    localparam logic [7:0] OP_RES_B = 8'h30;
    localparam logic [7:0] OP_RST_EN = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;

    // ==========================================================
    // status word fields
    localparam int unsigned BIT_WIP = 0;
    localparam int unsigned BIT_WEL = 1;
    localparam int unsigned BP_LSB = 2;
    localparam int unsigned BP_MSB = 6;
    localparam int unsigned BIT_LOCK_LO = 7;
    localparam int unsigned BIT_LOCK_HI = 8;
    localparam int unsigned BIT_QE = 9;
    localparam int unsigned BIT_PSUS = 10;
    localparam int unsigned OTP_LSB = 11;
    localparam int unsigned OTP_MSB = 13;
    localparam int unsigned BIT_INV = 14;
    localparam int unsigned BIT_ESUS = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [4:0] BP_NONE = 5'h00;

    // lock modes {hi, lo}
    localparam logic [1:0] LOCK_SOFT = 2'h0;
    localparam logic [1:0] LOCK_HW = 2'h1;

    // ==========================================================
    // frame bit counts (opcode plus data)
    localparam logic [4:0] CNT_OPCODE_LAST = 5'h07;
    localparam logic [4:0] CNT_OPCODE = 5'h08;
    localparam logic [4:0] CNT_WR8 = 5'h10;
    localparam logic [4:0] CNT_WR16 = 5'h18;
    localparam logic [4:0] CNT_SAT = 5'h19;

    // ==========================================================
    // timing
    localparam int unsigned SYS_CLK_PERIOD_NS = 25;
    localparam int unsigned STATUS_WRITE_TIME_NS = 5000000;
    localparam int unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_NS / SYS_CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WRITE = 1'b1
    } sfsp_state_e;

endpackage : sfsp_pkg

`default_nettype wire

/* rtl/sfsp_sync3.sv */
/*
 * sfsp_sync3: three-stage level synchroniser, per bit.
 * assumes: inputs are levels from another clock; output moves only once
 * the second and third stage agree.
 */
`default_nettype none

module sfsp_sync3 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // ==========================================================
    // stages
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // filter: a one-cycle disagreement is held off
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule // sfsp_sync3

`default_nettype wire

/* verif/sfsp_checker.sv */
/*
 * sfsp_checker: port-level assertions for sfsp_status_protect.
 * assumes: bound to the design top; host keeps cs high between frames.
 */
`default_nettype none

module sfsp_checker
    import sfsp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic so_oe_o,
    input wire logic [4:0] prot_level_o,
    input wire logic prot_invert_o,
    input wire logic chip_erase_ok_o,
    input wire logic write_latch_o,
    input wire logic quad_io_enable_o,
    input wire logic [2:0] otp_lock_o,
    input wire logic [15:0] nv_image_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    chk_oe_release: assert property (
        cs_n_i [*8] |-> !so_oe_o)
        else $error("output driven while deselected");
    chk_erase_gate: assert property (
        $stable(prot_level_o) |-> chip_erase_ok_o == (prot_level_o == BP_NONE))
        else $error("chip erase gate wrong");
    chk_otp_sticky: assert property (
        (otp_lock_o & $past(otp_lock_o)) == $past(otp_lock_o))
        else $error("otp lock bit cleared");
    chk_latch_rise: assert property (
        $rose(write_latch_o) |-> $past(cs_n_i))
        else $error("latch set inside a frame");
    chk_nv_latch: assert property (
        $changed(nv_image_o) |-> $past(write_latch_o))
        else $error("status written without latch");
    chk_nv_fixed: assert property (
        $stable({nv_image_o[15], nv_image_o[10], nv_image_o[1:0]}))
        else $error("fixed status bits written");
    chk_live_nv: assert property (
        $changed(nv_image_o) |-> ##[0:2] {prot_invert_o, quad_io_enable_o, otp_lock_o,
        prot_level_o} == {nv_image_o[14], nv_image_o[9], nv_image_o[13:11], nv_image_o[6:2]})
        else $error("live bits differ from image");
    chk_nv_frame: assert property (
        $changed(nv_image_o) |-> cs_n_i && $past(cs_n_i, 3))
        else $error("status written inside a frame");

    cov_busy_sig: cover property (so_oe_o && !cs_n_i);
    cov_nv_write: cover property ($changed(nv_image_o));
    cov_otp_set: cover property ($rose(otp_lock_o[0]));
endmodule // sfsp_checker

`default_nettype wire

/* verif/sfsp_host_model.sv */
/*
 * sfsp_host_model: behavioural spi mode 0 host, 32 ns serial clock.
 * assumes: bench calls start, send, rd and stop in frame order.
 */
`default_nettype none

module sfsp_host_model (
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o,
    input wire logic so_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end
    task automatic send(input logic [15:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            si_o = d[15-i];
            #16;
            sclk_o = 1'b1;
            #16;
            sclk_o = 1'b0;
        end
    endtask
    // mode 0, so no dummy bit after opcode
    task automatic start(input logic [7:0] op);
        cs_n_o = 1'b0;
        #16;
        send({op, 8'h00}, 8);
    endtask
    // si toggles: its value is of no significance while reading
    task automatic rd(input int n, output logic [15:0] v);
        v = 16'h0000;
        for (int i = 0; i < n; i++) begin
            si_o = ~si_o;
            #16;
            sclk_o = 1'b1;
            v = {v[14:0], so_i};
            #16;
            sclk_o = 1'b0;
        end
    endtask
    // caller decides the bit count before deselect
    task automatic stop();
        #16;
        cs_n_o = 1'b1;
        si_o = ~si_o;
        #250;
    endtask
endmodule // sfsp_host_model

`default_nettype wire

/* verif/serial_flash_status_protect_tb.sv */
/*
 * serial_flash_status_protect_tb: self-checking bench of the status block.
 * assumes: package, design, host model and checker compiled before it.
 */
`default_nettype none

module serial_flash_status_protect_tb
    import sfsp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0] n;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] elo;
        logic [7:0] ehi;
        logic ceok;
    } sfsp_row_s;
    localparam sfsp_row_s ROWS [4] = '{
        '{5'h10, 8'h7f, 8'hc6, 8'h7c, 8'h42, 1'b0},
        '{5'h08, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1},
        '{5'h10, 8'h08, 8'h08, 8'h08, 8'h08, 1'b0},
        '{5'h10, 8'h00, 8'h00, 8'h00, 8'h08, 1'b1}};
    logic sys_clk, sclk, cs_n, si, so, so_oe, ceok, latch;
    logic resetn = 1'b0;
    logic wp_n = 1'b1;
    logic a_busy = 1'b0;
    logic a_done = 1'b0;
    logic a_erase = 1'b0;
    logic [15:0] nv, v;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    sfsp_status_protect #(.TW_CYCLES(200)) dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .sclk_i(sclk), .cs_n_i(cs_n),
        .si_i(si), .so_o(so), .so_oe_o(so_oe), .wp_n_i(wp_n), .array_busy_i(a_busy),
        .array_done_i(a_done), .array_is_erase_i(a_erase), .prot_level_o(),
        .prot_invert_o(), .chip_erase_ok_o(ceok), .write_latch_o(latch),
        .quad_io_enable_o(), .otp_lock_o(), .nv_image_o(nv));
    sfsp_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // a hang ends the run as a failure
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // pins are {wp_n, busy, done, erase}, changed at falling edge
    task automatic pins(input logic [3:0] p);
        @(negedge sys_clk);
        {wp_n, a_busy, a_done, a_erase} = p;
    endtask
    task automatic power();
        @(negedge sys_clk);
        resetn = 1'b0;
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (10) @(negedge sys_clk);
    endtask
    task automatic cmd(input logic [7:0] op);
        host.start(op);
        host.stop();
    endtask
    task automatic rd(input logic [7:0] op, input int n, output logic [15:0] r);
        host.start(op);
        host.rd(n, r);
        host.stop();
    endtask
    task automatic wr(input int n, input logic [15:0] d);
        host.start(OP_SR_WRITE);
        host.send(d, n);
        host.stop();
    endtask
    task automatic wait_idle();
        logic [15:0] r;
        r = 16'h0001;
        for (int k = 0; k < 40 && r[0]; k++) begin
            rd(OP_RD_LO, 8, r);
        end
    endtask
    task automatic chk_rd(input logic [7:0] op, input logic [15:0] exp);
        rd(op, 8, v);
        chk(v, exp);
    endtask

    initial begin
        power();
        chk(16'({ceok, latch}), 16'h0002);
        chk_rd(OP_RD_HI, 16'h0000);
        // ==========================================================
        // ordinary status writes from the table
        for (int i = 0; i < 4; i++) begin
            cmd(OP_WR_EN);
            wr(ROWS[i].n, {ROWS[i].lo, ROWS[i].hi});
            rd(OP_RD_LO, 8, v);
            chk(16'(v[1:0]), 16'h0003);
            wait_idle();
            chk_rd(OP_RD_LO, 16'(ROWS[i].elo));
            chk_rd(OP_RD_HI, 16'(ROWS[i].ehi));
            chk(16'(ceok), 16'(ROWS[i].ceok));
        end
        // ==========================================================
        // refusals, repeat read, volatile write
        rd(OP_RD_HI, 16, v);
        chk(v, 16'h0808);
        wr(16, 16'h0400);
        wait_idle();
        chk_rd(OP_RD_LO, 16'h0000);
        cmd(OP_WR_EN);
        wr(12, 16'h0400);
        chk_rd(OP_RD_LO, 16'h0002);
        cmd(OP_WR_DIS);
        chk(16'(latch), 16'h0000);
        cmd(OP_WR_EN);
        cmd(OP_RST_EN);
        cmd(OP_RST);
        chk(16'(latch), 16'h0000);
        cmd(OP_VOL_WEN);
        wr(16, 16'h1000);
        chk_rd(OP_RD_LO, 16'h0010);
        chk(nv, 16'h0800);
        // ==========================================================
        // suspend flags, latch clear on completion, busy signal
        for (int j = 0; j < 2; j++) begin
            pins({3'b110, j == 0});
            rd(OP_RD_LO, 8, v);
            chk(16'(v[0]), 16'h0001);
            cmd(j ? OP_SUSP_B : OP_SUSP_A);
            chk_rd(OP_RD_HI, j ? 16'h000c : 16'h0088);
            cmd(j ? OP_RES_B : OP_RES_A);
            chk_rd(OP_RD_HI, 16'h0008);
        end
        cmd(OP_WR_EN);
        pins(4'b1110);
        pins(4'b1100);
        repeat (2) @(negedge sys_clk);
        chk(16'(latch), 16'h0000);
        host.start(OP_BUSY_SIG);
        repeat (10) @(negedge sys_clk);
        chk(16'({so_oe, so}), 16'h0003);
        pins(4'b1000);
        repeat (10) @(negedge sys_clk);
        chk(16'({so_oe, so}), 16'h0002);
        host.stop();
        chk(16'(so_oe), 16'h0000);
        // ==========================================================
        // lock modes, then power cycle
        cmd(OP_WR_EN);
        wr(16, 16'h8000);
        wait_idle();
        pins(4'b0000);
        cmd(OP_WR_EN);
        wr(16, 16'h8400);
        wait_idle();
        chk_rd(OP_RD_LO, 16'h0082);
        pins(4'b1000);
        wr(16, 16'h0401);
        wait_idle();
        chk_rd(OP_RD_HI, 16'h0009);
        cmd(OP_WR_EN);
        wr(16, 16'h0000);
        wait_idle();
        chk_rd(OP_RD_LO, 16'h0006);
        power();
        chk_rd(OP_RD_HI, 16'h0000);
        close_out();
    end
endmodule // serial_flash_status_protect_tb

bind sfsp_status_protect sfsp_checker chk (
    .sys_clk_i, .resetn_i, .cs_n_i, .so_oe_o, .prot_level_o, .prot_invert_o,
    .chip_erase_ok_o, .write_latch_o, .quad_io_enable_o, .otp_lock_o, .nv_image_o);

`default_nettype wire
